// ---- pkg/ucu_pkg.sv ----
// Constants, encodings and decode helpers of the engine command unit.
// Assumes a single sys_clk domain shared by all modules of the unit.
package ucu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command word layout
  localparam int CODE_LSB  = 16;
  localparam int PHASE_LSB = 8;
  localparam int BYTE_W    = 8;

  localparam logic [7:0] PHASE_COMMAND = 8'h05;
  localparam logic [7:0] PHASE_WRITE   = 8'h01;
  localparam logic [7:0] PHASE_READ    = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] OP_SET_ADDR     = 8'hD0;
  localparam logic [7:0] OP_CONFIG       = 8'hD8;
  localparam logic [7:0] OP_FRAME        = 8'hF5;
  localparam logic [7:0] OP_SELECT_BASE  = 8'h00;
  localparam logic [7:0] OP_SEL_CLR_BASE = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Status bits, data fields and reset values
  localparam int CMD_EMPTY_BIT   = 4;
  localparam int RESULT_FULL_BIT = 5;
  localparam int ADDR_EN_BIT     = 7;
  localparam int ADDR_W          = 7;
  localparam int CFG_BIT         = 0;
  localparam int FRAME_W         = 11;
  localparam int CTRL_EP_COUNT   = 2;

  localparam logic [ADDR_W-1:0] FUNC_ADDR_RESET = 7'h00;
  localparam logic [7:0]        RESULT_RESET    = 8'h00;

  typedef enum {KIND_SET_ADDR, KIND_CONFIG, KIND_FRAME, KIND_SELECT,
                KIND_SEL_CLR, KIND_OTHER} ucu_kind_t;

  typedef enum {ST_IDLE, ST_HELD} ucu_state_t;

  function automatic ucu_kind_t ucu_classify(input logic [7:0] code, input int num_ep);
    ucu_kind_t kind;
    kind = KIND_OTHER;
    if (code == OP_SET_ADDR)
      kind = KIND_SET_ADDR;
    else if (code == OP_CONFIG)
      kind = KIND_CONFIG;
    else if (code == OP_FRAME)
      kind = KIND_FRAME;
    else if (int'(code - OP_SELECT_BASE) < num_ep)
      kind = KIND_SELECT;
    else if (code >= OP_SEL_CLR_BASE && int'(code - OP_SEL_CLR_BASE) < num_ep)
      kind = KIND_SEL_CLR;
    return kind;
  endfunction : ucu_classify

endpackage : ucu_pkg

// ---- pkg/ucu_cmd_if.sv ----
// Carrier between the command core, the code decoder and the address control.
// Assumes all three sit on the same sys_clk.
interface ucu_cmd_if #(parameter int EP_W = 5);
  logic [7:0]                    code;
  ucu_pkg::ucu_kind_t            kind;
  logic [EP_W-1:0]               ep_index;
  logic                          addr_load;
  logic [7:0]                    addr_data;
  logic                          cfg_load;
  logic                          cfg_data;
  logic [ucu_pkg::ADDR_W-1:0]    function_address;
  logic                          function_enable;
  logic                          configured;

  modport decode (input code, output kind, ep_index);
  modport ctl    (input addr_load, addr_data, cfg_load, cfg_data,
                  output function_address, function_enable, configured);
  modport core   (output code, addr_load, addr_data, cfg_load, cfg_data,
                  input kind, ep_index, function_address, function_enable, configured);
endinterface : ucu_cmd_if

// ---- src/ucu_decoder.sv ----
// Classifies a command code and extracts the endpoint index it carries.
// Assumes the code is stable for the cycle in which it is used.
module ucu_decoder #(
  parameter int NUM_EP = 32,
  parameter int EP_W   = 5
) (
  ucu_cmd_if.decode bus
);

  logic [7:0] offset;

  always_comb
  begin
    bus.kind = ucu_pkg::ucu_classify(bus.code, NUM_EP);
    offset   = 8'h00;
    if (bus.kind == ucu_pkg::KIND_SELECT)
      offset = bus.code - ucu_pkg::OP_SELECT_BASE;
    else if (bus.kind == ucu_pkg::KIND_SEL_CLR)
      offset = bus.code - ucu_pkg::OP_SEL_CLR_BASE;
    bus.ep_index = offset[EP_W-1:0];
  end

endmodule : ucu_decoder

// ---- src/ucu_addr_ctl.sv ----
// Function address, function enable and configured state of the device.
// Assumes bus reset and status stage completion are one-cycle pulses.
module ucu_addr_ctl (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic usb_bus_reset,
  input  wire logic status_stage_done,
  ucu_cmd_if.ctl    bus
);

  logic [ucu_pkg::ADDR_W-1:0] address;
  logic [ucu_pkg::ADDR_W-1:0] next_address;
  logic                       enable;
  logic                       next_enable;
  logic [ucu_pkg::ADDR_W-1:0] pend_address;
  logic [ucu_pkg::ADDR_W-1:0] next_pend_address;
  logic                       pend_enable;
  logic                       next_pend_enable;
  logic                       pending;
  logic                       next_pending;
  logic                       configured;
  logic                       next_configured;

  always_comb
  begin
    next_address      = address;
    next_enable       = enable;
    next_pend_address = pend_address;
    next_pend_enable  = pend_enable;
    next_pending      = pending;
    next_configured   = configured;
    if (usb_bus_reset)
    begin
      next_address    = ucu_pkg::FUNC_ADDR_RESET;
      next_enable     = 1'b1;
      next_pending    = 1'b0;
      next_configured = 1'b0;
    end
    else
    begin
      if (status_stage_done && pending)
      begin
        next_address = pend_address;
        next_enable  = pend_enable;
        next_pending = 1'b0;
      end
      if (bus.addr_load)
      begin
        next_pend_address = bus.addr_data[ucu_pkg::ADDR_W-1:0];
        next_pend_enable  = bus.addr_data[ucu_pkg::ADDR_EN_BIT];
        next_pending      = 1'b1;
      end
      if (bus.cfg_load)
        next_configured = bus.cfg_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      address      <= ucu_pkg::FUNC_ADDR_RESET;
      enable       <= 1'b0;
      pend_address <= ucu_pkg::FUNC_ADDR_RESET;
      pend_enable  <= 1'b0;
      pending      <= 1'b0;
      configured   <= 1'b0;
    end
    else
    begin
      address      <= next_address;
      enable       <= next_enable;
      pend_address <= next_pend_address;
      pend_enable  <= next_pend_enable;
      pending      <= next_pending;
      configured   <= next_configured;
    end
  end

  assign bus.function_address = address;
  assign bus.function_enable  = enable;
  assign bus.configured       = configured;

endmodule : ucu_addr_ctl

// ---- src/ucu_top.sv ----
// Command unit of the serial interface engine: command and data phases,
// handshake flags, endpoint strobes and the address filter for tokens.
// Assumes register writes arrive as one-cycle strobes on sys_clk and that
// the USB side presents tokens and events synchronous to sys_clk.
//
// Notes on behaviour
// - Code D0 sets address, one write byte
// - Code D8 configures device, one write byte
// - Code F5 reads frame number, one or two bytes
// - Endpoint index is select code, read optional
// - 40 plus index clears; write sets status
// - Command or write completion sets empty flag
// - New address applies after status stage
// - Bus reset: address zero, enable one
// - Disabled ignores all; enabled matches address only
// - Address loaded only by command, zero at reset
// - Configured device lets other endpoints answer
// - Control endpoints answer without configuration
// - Read phase 02 raises full when byte ready
// - Multi-byte results come low byte first
module ucu_top #(
  parameter int NUM_EP = 32,
  parameter int EP_W   = $clog2(NUM_EP)
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      cmd_write,
  input  wire logic [31:0]               cmd_word,
  input  wire logic                      irq_clear_write,
  input  wire logic [31:0]               irq_clear_word,
  input  wire logic                      usb_bus_reset,
  input  wire logic                      status_stage_done,
  input  wire logic [ucu_pkg::FRAME_W-1:0] sof_frame_number,
  input  wire logic [NUM_EP*8-1:0]       ep_status_bytes,
  input  wire logic                      token_valid,
  input  wire logic [ucu_pkg::ADDR_W-1:0] token_address,
  input  wire logic [EP_W-1:0]           token_endpoint,
  output logic                           command_empty_flag,
  output logic                           result_full_flag,
  output logic [7:0]                     engine_result_reg,
  output logic                           ep_select_strobe,
  output logic                           ep_clear_irq_strobe,
  output logic                           ep_set_status_strobe,
  output logic [EP_W-1:0]                ep_strobe_index,
  output logic [7:0]                     ep_strobe_data,
  output logic                           token_accept,
  output logic [ucu_pkg::ADDR_W-1:0]     function_address,
  output logic                           function_enable,
  output logic                           device_configured
);

  localparam int HI_W = ucu_pkg::FRAME_W - ucu_pkg::BYTE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  ucu_cmd_if #(.EP_W(EP_W)) cmd_bus ();

  ucu_decoder #(
    .NUM_EP (NUM_EP),
    .EP_W   (EP_W)
  ) u_decoder (
    .bus (cmd_bus.decode)
  );

  ucu_addr_ctl u_addr_ctl (
    .sys_clk           (sys_clk),
    .reset_n           (reset_n),
    .usb_bus_reset     (usb_bus_reset),
    .status_stage_done (status_stage_done),
    .bus               (cmd_bus.ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command word fields

  logic [7:0] word_code;
  logic [7:0] word_phase;
  logic       is_command;
  logic       is_write;
  logic       is_read;

  assign word_code  = cmd_word[ucu_pkg::CODE_LSB +: ucu_pkg::BYTE_W];
  assign word_phase = cmd_word[ucu_pkg::PHASE_LSB +: ucu_pkg::BYTE_W];
  assign is_command = cmd_write && (word_phase == ucu_pkg::PHASE_COMMAND);
  assign is_write   = cmd_write && (word_phase == ucu_pkg::PHASE_WRITE);
  assign is_read    = cmd_write && (word_phase == ucu_pkg::PHASE_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing state

  ucu_pkg::ucu_state_t state;
  ucu_pkg::ucu_state_t next_state;
  logic [7:0]          held_code;
  logic [7:0]          next_held_code;
  logic                read_second;
  logic                next_read_second;
  logic [HI_W-1:0]     frame_high;
  logic [HI_W-1:0]     next_frame_high;
  logic                next_empty;
  logic                next_full;
  logic [7:0]          next_result;
  logic                next_sel;
  logic                next_clr;
  logic                next_set;
  logic [EP_W-1:0]     next_index;
  logic [7:0]          next_data;
  logic                next_accept;
  logic                set_empty;
  logic                set_full;
  logic                is_control_ep;

  // Write phases carry data, not code: decode the held code then
  assign cmd_bus.code      = is_write ? held_code : word_code;
  assign cmd_bus.addr_data = word_code;
  assign cmd_bus.cfg_data  = word_code[ucu_pkg::CFG_BIT];
  assign cmd_bus.addr_load = is_write && (state == ucu_pkg::ST_HELD)
                             && (cmd_bus.kind == ucu_pkg::KIND_SET_ADDR);
  assign cmd_bus.cfg_load  = is_write && (state == ucu_pkg::ST_HELD)
                             && (cmd_bus.kind == ucu_pkg::KIND_CONFIG);

  assign is_control_ep = int'(token_endpoint) < ucu_pkg::CTRL_EP_COUNT;

  always_comb
  begin
    next_state       = state;
    next_held_code   = held_code;
    next_read_second = read_second;
    next_frame_high  = frame_high;
    next_result      = engine_result_reg;
    next_sel         = 1'b0;
    next_clr         = 1'b0;
    next_set         = 1'b0;
    next_index       = ep_strobe_index;
    next_data        = ep_strobe_data;
    set_empty        = 1'b0;
    set_full         = 1'b0;
    if (is_command)
    begin
      set_empty        = 1'b1;
      next_state       = ucu_pkg::ST_HELD;
      next_held_code   = word_code;
      next_read_second = 1'b0;
      next_index       = cmd_bus.ep_index;
      if (cmd_bus.kind == ucu_pkg::KIND_SELECT)
        next_sel = 1'b1;
      if (cmd_bus.kind == ucu_pkg::KIND_SEL_CLR)
      begin
        next_sel = 1'b1;
        next_clr = 1'b1;
      end
    end
    else if (is_write && state == ucu_pkg::ST_HELD)
    begin
      set_empty  = 1'b1;
      next_state = ucu_pkg::ST_IDLE;
      if (cmd_bus.kind == ucu_pkg::KIND_SEL_CLR)
      begin
        next_set   = 1'b1;
        next_index = cmd_bus.ep_index;
        next_data  = word_code;
      end
    end
    else if (is_read && state == ucu_pkg::ST_HELD && word_code == held_code)
    begin
      set_full         = 1'b1;
      next_read_second = 1'b1;
      next_result      = ucu_pkg::RESULT_RESET;
      case (cmd_bus.kind)
        ucu_pkg::KIND_FRAME:
        begin
          if (!read_second)
          begin
            next_result     = sof_frame_number[ucu_pkg::BYTE_W-1:0];
            next_frame_high = sof_frame_number[ucu_pkg::FRAME_W-1:ucu_pkg::BYTE_W];
          end
          else
            next_result = {{(ucu_pkg::BYTE_W-HI_W){1'b0}}, frame_high};
        end
        ucu_pkg::KIND_SELECT,
        ucu_pkg::KIND_SEL_CLR:
          next_result = ep_status_bytes[int'(cmd_bus.ep_index)*ucu_pkg::BYTE_W
                                        +: ucu_pkg::BYTE_W];
        default:
          next_result = ucu_pkg::RESULT_RESET;
      endcase
    end

    // Set wins over a clear in the same cycle
    next_empty = (command_empty_flag
                  && !(irq_clear_write && irq_clear_word[ucu_pkg::CMD_EMPTY_BIT]))
                 || set_empty;
    next_full  = (result_full_flag
                  && !(irq_clear_write && irq_clear_word[ucu_pkg::RESULT_FULL_BIT]))
                 || set_full;

    next_accept = token_valid && cmd_bus.function_enable
                  && (token_address == cmd_bus.function_address)
                  && (is_control_ep || cmd_bus.configured);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state                <= ucu_pkg::ST_IDLE;
      held_code            <= ucu_pkg::RESULT_RESET;
      read_second          <= 1'b0;
      frame_high           <= '0;
      command_empty_flag   <= 1'b0;
      result_full_flag     <= 1'b0;
      engine_result_reg    <= ucu_pkg::RESULT_RESET;
      ep_select_strobe     <= 1'b0;
      ep_clear_irq_strobe  <= 1'b0;
      ep_set_status_strobe <= 1'b0;
      ep_strobe_index      <= '0;
      ep_strobe_data       <= ucu_pkg::RESULT_RESET;
      token_accept         <= 1'b0;
      function_address     <= ucu_pkg::FUNC_ADDR_RESET;
      function_enable      <= 1'b0;
      device_configured    <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      held_code            <= next_held_code;
      read_second          <= next_read_second;
      frame_high           <= next_frame_high;
      command_empty_flag   <= next_empty;
      result_full_flag     <= next_full;
      engine_result_reg    <= next_result;
      ep_select_strobe     <= next_sel;
      ep_clear_irq_strobe  <= next_clr;
      ep_set_status_strobe <= next_set;
      ep_strobe_index      <= next_index;
      ep_strobe_data       <= next_data;
      token_accept         <= next_accept;
      function_address     <= cmd_bus.function_address;
      function_enable      <= cmd_bus.function_enable;
      device_configured    <= cmd_bus.configured;
    end
  end

endmodule : ucu_top

// ---- bench/ucu_top_checker.sv ----
// Concurrent checks on the ports of the engine command unit.
// Assumes one sys_clk domain and the asynchronous active-low reset_n.
module ucu_top_checker #(
  parameter int NUM_EP = 32,
  parameter int EP_W   = 5
) (
  input wire logic                       sys_clk,
  input wire logic                       reset_n,
  input wire logic                       cmd_write,
  input wire logic [31:0]                cmd_word,
  input wire logic                       irq_clear_write,
  input wire logic [31:0]                irq_clear_word,
  input wire logic                       usb_bus_reset,
  input wire logic                       status_stage_done,
  input wire logic                       token_valid,
  input wire logic [ucu_pkg::ADDR_W-1:0] token_address,
  input wire logic [EP_W-1:0]            token_endpoint,
  input wire logic                       command_empty_flag,
  input wire logic                       result_full_flag,
  input wire logic                       ep_select_strobe,
  input wire logic                       ep_clear_irq_strobe,
  input wire logic [EP_W-1:0]            ep_strobe_index,
  input wire logic                       token_accept,
  input wire logic [ucu_pkg::ADDR_W-1:0] function_address,
  input wire logic                       function_enable,
  input wire logic                       device_configured
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  //////////////////////////////////////////////////////////////
  sequence cmd_s;
    cmd_write && cmd_word[15:8] == 8'h05;
  endsequence

  empty_on_cmd_a: assert property (cmd_s |=> command_empty_flag)
    else $error("empty flag missed after command");
  empty_cause_a: assert property ($rose(command_empty_flag) |->
    $past(cmd_write) && $past(cmd_word[15:8]) inside {8'h05, 8'h01})
    else $error("empty flag rose without cause");
  empty_holds_a: assert property (command_empty_flag &&
    !(irq_clear_write && irq_clear_word[4]) |=> command_empty_flag)
    else $error("empty flag dropped without clear");
  full_cause_a: assert property ($rose(result_full_flag) |->
    $past(cmd_write) && $past(cmd_word[15:8]) == 8'h02)
    else $error("full flag rose without read phase");
  select_ep_a: assert property (cmd_s ##0 cmd_word[23:16] < NUM_EP |=>
    ep_select_strobe && !ep_clear_irq_strobe
    && ep_strobe_index == $past(cmd_word[16+:EP_W])) else $error("select strobe wrong");
  sel_clear_a: assert property (cmd_s ##0 cmd_word[23:16] >= 8'h40
    ##0 cmd_word[23:16] < 8'h40 + NUM_EP |=> ep_select_strobe && ep_clear_irq_strobe)
    else $error("clear strobe missed");
  token_match_a: assert property (token_valid |=> token_accept ==
    (function_enable && $past(token_address) == function_address
     && ($past(token_endpoint) < 2 || device_configured))) else $error("token filter wrong");
  bus_reset_a: assert property (usb_bus_reset |-> ##2
    function_address == 7'h00 && function_enable && !device_configured)
    else $error("bus reset state wrong");
  addr_cause_a: assert property ($changed(function_address) |->
    $past(status_stage_done, 2) || $past(usb_bus_reset, 2)) else $error("address moved early");
endmodule : ucu_top_checker

bind ucu_top ucu_top_checker #(.NUM_EP(NUM_EP), .EP_W(EP_W)) i_ucu_top_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .cmd_write(cmd_write), .cmd_word(cmd_word),
  .irq_clear_write(irq_clear_write), .irq_clear_word(irq_clear_word),
  .usb_bus_reset(usb_bus_reset), .status_stage_done(status_stage_done),
  .token_valid(token_valid), .token_address(token_address), .token_endpoint(token_endpoint),
  .command_empty_flag(command_empty_flag), .result_full_flag(result_full_flag),
  .ep_select_strobe(ep_select_strobe), .ep_clear_irq_strobe(ep_clear_irq_strobe),
  .ep_strobe_index(ep_strobe_index), .token_accept(token_accept),
  .function_address(function_address), .function_enable(function_enable),
  .device_configured(device_configured)
);

// ---- bench/ucu_sw_model.sv ----
// Software side: writes the command and clear registers, polls flags.
// Assumes flags are looked at on the falling edge of sys_clk.
module ucu_sw_model (
  input wire logic   sys_clk,
  input wire logic   command_empty_flag,
  input wire logic   result_full_flag,
  input wire logic [7:0] engine_result_reg,
  output logic       cmd_write,
  output logic [31:0] cmd_word,
  output logic       irq_clear_write,
  output logic [31:0] irq_clear_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_write = 1'b0;
    cmd_word = 32'h0;
    irq_clear_write = 1'b0;
    irq_clear_word = 32'h0;
  end

  task automatic issue(input logic [7:0] code, input logic [7:0] phase);
    @(negedge sys_clk);
    cmd_write = 1'b1;
    cmd_word = {8'h00, code, phase, 8'h00};
    @(negedge sys_clk);
    cmd_write = 1'b0;
    cmd_word = ~cmd_word;
  endtask : issue

  task automatic clear(input logic [7:0] mask);
    @(negedge sys_clk);
    irq_clear_write = 1'b1;
    irq_clear_word = {24'h0, mask};
    @(negedge sys_clk);
    irq_clear_write = 1'b0;
    irq_clear_word = ~irq_clear_word;
  endtask : clear

  task automatic wait_flag(input int bit_sel);
    for (int i = 0; i < 8; i++)
      if (bit_sel == 4 ? !command_empty_flag : !result_full_flag)
        @(negedge sys_clk);
  endtask : wait_flag

  task automatic write_cmd(input logic [7:0] code, input logic [7:0] data);
    issue(code, 8'h05);
    wait_flag(4);
    clear(8'h10);
    issue(data, 8'h01);
    wait_flag(4);
    clear(8'h10);
  endtask : write_cmd

  task automatic read_byte(input logic [7:0] code, output logic [7:0] val);
    issue(code, 8'h02);
    wait_flag(5);
    val = engine_result_reg;
    clear(8'h20);
  endtask : read_byte
endmodule : ucu_sw_model

// ---- bench/tb_top.sv ----
// Self-checking bench of the engine command unit with four endpoints.
// Assumes the checker is bound to ucu_top by its own file.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NUM_EP = 4;
  localparam int EP_W   = 2;

  logic        sys_clk, reset_n, cmd_write, irq_clear_write, usb_bus_reset;
  logic        status_stage_done, token_valid, command_empty_flag, result_full_flag;
  logic        ep_select_strobe, ep_clear_irq_strobe, ep_set_status_strobe, token_accept;
  logic        function_enable, device_configured;
  logic [31:0] cmd_word, irq_clear_word, ep_status_bytes, rng;
  logic [10:0] sof_frame_number;
  logic [6:0]  token_address, function_address;
  logic [1:0]  token_endpoint, ep_strobe_index;
  logic [7:0]  engine_result_reg, ep_strobe_data, val, code;
  int          mismatches, n_checks, exp_addr, exp_en, exp_cfg;

  ucu_top #(.NUM_EP(NUM_EP), .EP_W(EP_W)) i_ucu_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .irq_clear_write(irq_clear_write), .irq_clear_word(irq_clear_word),
    .usb_bus_reset(usb_bus_reset), .status_stage_done(status_stage_done),
    .sof_frame_number(sof_frame_number), .ep_status_bytes(ep_status_bytes),
    .token_valid(token_valid), .token_address(token_address),
    .token_endpoint(token_endpoint), .command_empty_flag(command_empty_flag),
    .result_full_flag(result_full_flag), .engine_result_reg(engine_result_reg),
    .ep_select_strobe(ep_select_strobe), .ep_clear_irq_strobe(ep_clear_irq_strobe),
    .ep_set_status_strobe(ep_set_status_strobe), .ep_strobe_index(ep_strobe_index),
    .ep_strobe_data(ep_strobe_data), .token_accept(token_accept),
    .function_address(function_address), .function_enable(function_enable),
    .device_configured(device_configured));

  ucu_sw_model i_ucu_sw_model (
    .sys_clk(sys_clk), .command_empty_flag(command_empty_flag),
    .result_full_flag(result_full_flag), .engine_result_reg(engine_result_reg),
    .cmd_write(cmd_write), .cmd_word(cmd_word), .irq_clear_write(irq_clear_write),
    .irq_clear_word(irq_clear_word));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic tok(input logic [6:0] a, input logic [1:0] ep);
    @(negedge sys_clk);
    token_valid = 1'b1;
    token_address = a;
    token_endpoint = ep;
    @(negedge sys_clk);
    token_valid = 1'b0;
    chk(token_accept, exp_en && a == exp_addr && (ep < 2 || exp_cfg), "token");
  endtask : tok

  // Pulse bus reset or status stage, then let the state settle
  task automatic ev(input bit bus);
    @(negedge sys_clk);
    usb_bus_reset = bus;
    status_stage_done = !bus;
    @(negedge sys_clk);
    usb_bus_reset = 1'b0;
    status_stage_done = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : ev

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    results();
  end

  initial
  begin
    rng = 32'h4718;
    reset_n = 1'b0;
    usb_bus_reset = 1'b0;
    status_stage_done = 1'b0;
    token_valid = 1'b0;
    token_address = rng[6:0];
    token_endpoint = rng[8:7];
    sof_frame_number = rng[10:0];
    ep_status_bytes = rng;
    {exp_addr, exp_en, exp_cfg} = '0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    chk({function_enable, device_configured, function_address}, 9'h000, "reset");
    i_ucu_sw_model.issue(8'h55, 8'h01);
    chk(command_empty_flag, 1'b0, "stray write");
    tok(7'h00, 2'h0);
    ev(1'b1);
    exp_en = 1;
    chk({function_enable, function_address}, 8'h80, "bus reset");
    tok(7'h00, 2'h0);
    tok(7'h00, 2'h2);
    rng = xs();
    val = {1'b1, rng[6:0]};
    i_ucu_sw_model.write_cmd(8'hD0, val);
    chk(function_address, 7'h00, "early address");
    tok(val[6:0], 2'h0);
    ev(1'b0);
    exp_addr = val[6:0];
    chk({function_enable, function_address}, val, "new address");
    i_ucu_sw_model.write_cmd(8'hD8, 8'h01);
    exp_cfg = 1;
    chk(device_configured, 1'b1, "configured");
    repeat (24)
    begin
      rng = xs();
      tok(rng[0] ? exp_addr[6:0] : rng[7:1], rng[9:8]);
    end
    rng = xs();
    sof_frame_number = rng[10:0];
    i_ucu_sw_model.issue(8'hF5, 8'h05);
    i_ucu_sw_model.wait_flag(4);
    i_ucu_sw_model.clear(8'h10);
    i_ucu_sw_model.issue(8'hF5, 8'h02);
    chk(result_full_flag, 1'b1, "full flag");
    chk(engine_result_reg, sof_frame_number[7:0], "frame low");
    i_ucu_sw_model.clear(8'h20);
    i_ucu_sw_model.read_byte(8'hF5, val);
    chk(val, {5'h00, sof_frame_number[10:8]}, "frame high");
    ep_status_bytes = xs();
    for (int i = 0; i < 8; i++)
    begin
      code = (i < 4) ? 8'(i) : 8'(8'h3C + i);
      i_ucu_sw_model.issue(code, 8'h05);
      chk({ep_select_strobe, ep_clear_irq_strobe, ep_strobe_index},
          {1'b1, 1'(i >= 4), 2'(i % 4)}, "strobes");
      i_ucu_sw_model.wait_flag(4);
      i_ucu_sw_model.clear(8'h10);
      i_ucu_sw_model.read_byte(code, val);
      chk(val, ep_status_bytes[(i % 4) * 8 +: 8], "status byte");
    end
    rng = xs();
    i_ucu_sw_model.issue(8'h41, 8'h05);
    i_ucu_sw_model.wait_flag(4);
    i_ucu_sw_model.clear(8'h10);
    i_ucu_sw_model.issue(rng[7:0], 8'h01);
    chk({ep_set_status_strobe, ep_strobe_index, ep_strobe_data},
        {1'b1, 2'h1, rng[7:0]}, "set status");
    i_ucu_sw_model.wait_flag(4);
    chk(command_empty_flag, 1'b1, "write done");
    i_ucu_sw_model.clear(8'h10);
    i_ucu_sw_model.write_cmd(8'hD0, {1'b0, rng[14:8]});
    ev(1'b0);
    {exp_en, exp_addr} = {32'h0, 25'h0, rng[14:8]};
    tok(rng[14:8], 2'h0);
    ev(1'b1);
    {exp_en, exp_addr, exp_cfg} = {32'h1, 32'h0, 32'h0};
    chk({function_enable, device_configured, function_address}, 9'h100, "reset again");
    tok(7'h00, 2'h1);
    tok(7'h00, 2'h3);
    results();
  end
endmodule : tb_top
